// *** otp_eprom_model.sv ***
module otp_eprom_model #(
   parameter logic [7:0] MAKER_CODE  = 8'h97,  // arbitrary value, odd parity
   parameter logic [7:0] DEVICE_CODE = 8'h0E   // arbitrary value, odd parity
) (
   // pins from the host
   input  wire otp_prog_pkg::pins_type pins,
   input  wire logic                   stuck,
   // data back to the host
   output logic [7:0]                  data_pins_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // array and output control
   // ---------------------------------------------------------------
   logic [7:0] mem [int];
   logic [7:0] val;
   logic [7:0] held = 8'h00;
   logic       drive;
   function automatic logic [7:0] rd(input logic [18:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : otp_prog_pkg::ERASED;
   endfunction : rd
   // verify runs with chip select high while vpp is raised
   assign drive = !pins.oe_b && (pins.vpp_raise ? pins.ce_b : !pins.ce_b);
   always @(posedge pins.ce_b) begin
      if (pins.vpp_raise && pins.vcc_raise && pins.oe_b && pins.data_oe && !stuck) begin
         mem[int'(pins.word_addr)] = rd(pins.word_addr) & pins.data_out;
      end
   end
   always @* begin
      // identify only answers with every address line but 0 and 9 low
      if (pins.id_high_voltage && pins.word_addr[18:10] == '0 && pins.word_addr[8:1] == '0) begin
         val = pins.word_addr[0] ? DEVICE_CODE : MAKER_CODE;
      end else begin
         val = rd(pins.word_addr);
      end
      if (drive) begin
         held = val;
      end
   end
   // released bus shows the inverse of the last byte, never a stale copy
   assign data_pins_in = drive ? val : ~held;
endmodule : otp_eprom_model

// *** otp_prog_pkg.sv ***
package otp_prog_pkg;

   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W             = 19;
   localparam int DATA_W             = 8;
   localparam int WORDS              = 524288;
   localparam int ID_SELECT_BIT      = 0;
   localparam int ID_TRIGGER_BIT     = 9;
   localparam logic [7:0] ERASED     = 8'hFF;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ             = 40000000;
   localparam int PULSE_US           = 100;
   localparam int SETUP_US           = 2;
   localparam int ACCESS_NS          = 150;
   localparam int PULSE_CYCLES       = (PULSE_US * (CLK_HZ / 1000000));
   localparam int SETUP_CYCLES       = (SETUP_US * (CLK_HZ / 1000000));
   localparam int ACCESS_CYCLES      = (ACCESS_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int MAX_PULSES         = 25;
   localparam int TIMER_W            = 16;
   localparam int TRY_W              = 5;

   // ---------------------------------------------------------------
   // command codes and states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_READ, CMD_PROGRAM_ALL, CMD_VERIFY_ALL, CMD_IDENTIFY
   } cmd_type;

   typedef enum logic [3:0] {
      ST_IDLE, ST_SETUP, ST_PULSE, ST_GAP, ST_VERIFY, ST_SAMPLE,
      ST_NEXT, ST_FINAL_SETUP, ST_FINAL_READ, ST_DONE
   } state_type;

   typedef struct packed {
      logic              ce_b;
      logic              oe_b;
      logic              vpp_raise;
      logic              vcc_raise;
      logic              id_high_voltage;
      logic [ADDR_W-1:0] word_addr;
      logic [DATA_W-1:0] data_out;
      logic              data_oe;
   } pins_type;

   typedef struct packed {
      logic              busy;
      logic              done;
      logic              fail;
      logic [ADDR_W-1:0] fail_addr;
      logic [DATA_W-1:0] rdata;
   } status_type;

endpackage : otp_prog_pkg

// *** otp_programmer.sv ***
// Summary of operation
// - programmer drives all eight data_pins together when writing a byte.
// - fast program mode: raised vpp, raised vcc, output gate high.
// - write byte with one 100 us chip select low pulse after setup.
// - on mismatch pulse again, at most 25 pulses per address.
// - loop every address in order, then verify all at nominal supplies.
// - parallel devices share all inputs except chip select.
// - verify with output gate low and vpp raised; device drives byte.
// - identify: trigger line at high voltage, others but select low.
// - decode chip select per device, share gate as the read strobe.
module otp_programmer #(
   parameter int ADDR_W     = otp_prog_pkg::ADDR_W,
   parameter int MAX_PULSES = otp_prog_pkg::MAX_PULSES
) (
   // clock and reset
   input  wire logic                            mclk,
   input  wire logic                            rst_b,
   // command side
   input  wire logic                            start,
   input  wire otp_prog_pkg::cmd_type           cmd,
   input  wire logic [ADDR_W-1:0]               cmd_addr,
   input  wire logic [ADDR_W-1:0]               last_addr,
   input  wire logic [7:0]                      cmd_data,
   input  wire logic                            id_byte_select_line,
   // device pins, status, and per-address data for program and verify loops
   output otp_prog_pkg::pins_type               pins,
   output otp_prog_pkg::status_type             status,
   input  wire logic [7:0]                      image_data,
   // data pins from device
   input  wire logic [7:0]                      data_pins_in
);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   if (ADDR_W != otp_prog_pkg::ADDR_W) begin : g_bad_addr
      $error("address width must match device");
   end
   if (MAX_PULSES < 1 || MAX_PULSES > 31) begin : g_bad_pulses
      $error("pulse limit out of range");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      otp_prog_pkg::state_type              st;
      otp_prog_pkg::cmd_type                cmd;
      logic [otp_prog_pkg::TIMER_W-1:0]     timer;
      logic [otp_prog_pkg::TRY_W-1:0]       tries;
      logic [ADDR_W-1:0]                    last;
      logic [7:0]                           want;
      logic [7:0]                           din_s1;
      logic [7:0]                           din_s2;
      otp_prog_pkg::pins_type               pins;
      otp_prog_pkg::status_type             status;
   } core_type;

   core_type s_q;
   core_type s_d;

   localparam logic [otp_prog_pkg::TIMER_W-1:0] T_PULSE =
      otp_prog_pkg::TIMER_W'(otp_prog_pkg::PULSE_CYCLES - 1);
   // one spare cycle: data_out lags the address by a cycle in setup
   localparam logic [otp_prog_pkg::TIMER_W-1:0] T_SETUP =
      otp_prog_pkg::TIMER_W'(otp_prog_pkg::SETUP_CYCLES);
   // sampling waits two extra cycles for the input synchroniser
   localparam logic [otp_prog_pkg::TIMER_W-1:0] T_ACCESS =
      otp_prog_pkg::TIMER_W'(otp_prog_pkg::ACCESS_CYCLES + 1);
   localparam logic [otp_prog_pkg::TRY_W-1:0] TRY_LIMIT =
      otp_prog_pkg::TRY_W'(MAX_PULSES);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.din_s1 = data_pins_in;
      s_d.din_s2 = s_q.din_s1;
      s_d.status.done = 1'b0;
      if (s_q.timer != '0) begin
         s_d.timer = s_q.timer - 1'b1;
      end
      unique case (s_q.st)
         otp_prog_pkg::ST_IDLE: begin
            s_d.pins.ce_b    = 1'b1;
            s_d.pins.oe_b    = 1'b1;
            s_d.pins.data_oe = 1'b0;
            if (start) begin
               s_d.cmd              = cmd;
               s_d.last             = last_addr;
               s_d.status.busy      = 1'b1;
               s_d.status.fail      = 1'b0;
               s_d.tries            = '0;
               s_d.timer            = T_SETUP;
               s_d.pins.word_addr   = cmd_addr;
               s_d.pins.vpp_raise   = (cmd == otp_prog_pkg::CMD_PROGRAM_ALL);
               s_d.pins.vcc_raise   = (cmd == otp_prog_pkg::CMD_PROGRAM_ALL);
               if (cmd == otp_prog_pkg::CMD_IDENTIFY) begin
                  s_d.pins.word_addr = '0;
                  s_d.pins.word_addr[otp_prog_pkg::ID_SELECT_BIT] = id_byte_select_line;
                  s_d.pins.id_high_voltage = 1'b1;
               end
               if (cmd == otp_prog_pkg::CMD_PROGRAM_ALL) begin
                  s_d.st = otp_prog_pkg::ST_SETUP;
               end else begin
                  s_d.st = otp_prog_pkg::ST_FINAL_SETUP;
               end
            end
         end
         otp_prog_pkg::ST_SETUP: begin
            // address, data and vpp settle before the pulse
            s_d.want          = image_data;
            s_d.pins.data_out = image_data;
            s_d.pins.data_oe  = 1'b1;
            s_d.pins.oe_b     = 1'b1;
            if (s_q.timer == '0) begin
               s_d.pins.ce_b = 1'b0;
               s_d.timer     = T_PULSE;
               s_d.tries     = s_q.tries + 1'b1;
               s_d.st        = otp_prog_pkg::ST_PULSE;
            end
         end
         otp_prog_pkg::ST_PULSE: begin
            if (s_q.timer == '0) begin
               s_d.pins.ce_b = 1'b1;
               s_d.timer     = T_SETUP;
               s_d.st        = otp_prog_pkg::ST_GAP;
            end
         end
         otp_prog_pkg::ST_GAP: begin
            // data hold, then release the bus before the gate opens
            if (s_q.timer == '0) begin
               s_d.pins.data_oe = 1'b0;
               s_d.timer        = T_SETUP;
               s_d.st           = otp_prog_pkg::ST_VERIFY;
            end
         end
         otp_prog_pkg::ST_VERIFY: begin
            if (s_q.timer == '0) begin
               s_d.pins.oe_b = 1'b0;
               s_d.timer     = T_ACCESS;
               s_d.st        = otp_prog_pkg::ST_SAMPLE;
            end
         end
         otp_prog_pkg::ST_SAMPLE: begin
            if (s_q.timer == '0) begin
               s_d.pins.oe_b = 1'b1;
               s_d.timer     = T_SETUP;
               if (s_q.din_s2 == s_q.want) begin
                  s_d.st = otp_prog_pkg::ST_NEXT;
               end else if (s_q.tries >= TRY_LIMIT) begin
                  s_d.status.fail      = 1'b1;
                  s_d.status.fail_addr = s_q.pins.word_addr;
                  s_d.st               = otp_prog_pkg::ST_DONE;
               end else begin
                  s_d.st = otp_prog_pkg::ST_SETUP;
               end
            end
         end
         otp_prog_pkg::ST_NEXT: begin
            s_d.tries = '0;
            // full setup again, counted from the new address
            s_d.timer = T_SETUP;
            if (s_q.pins.word_addr == s_q.last) begin
               // second pass at nominal supplies
               s_d.pins.vpp_raise = 1'b0;
               s_d.pins.vcc_raise = 1'b0;
               s_d.pins.word_addr = cmd_addr;
               s_d.cmd            = otp_prog_pkg::CMD_VERIFY_ALL;
               s_d.st             = otp_prog_pkg::ST_FINAL_SETUP;
            end else begin
               s_d.pins.word_addr = s_q.pins.word_addr + 1'b1;
               s_d.st             = otp_prog_pkg::ST_SETUP;
            end
         end
         otp_prog_pkg::ST_FINAL_SETUP: begin
            s_d.want = image_data;
            if (s_q.timer == '0) begin
               s_d.pins.ce_b = 1'b0;
               s_d.pins.oe_b = 1'b0;
               s_d.timer     = T_ACCESS;
               s_d.st        = otp_prog_pkg::ST_FINAL_READ;
            end
         end
         otp_prog_pkg::ST_FINAL_READ: begin
            if (s_q.timer == '0) begin
               s_d.pins.ce_b     = 1'b1;
               s_d.pins.oe_b     = 1'b1;
               s_d.status.rdata  = s_q.din_s2;
               s_d.timer         = T_SETUP;
               if (s_q.cmd == otp_prog_pkg::CMD_VERIFY_ALL) begin
                  if (s_q.din_s2 != s_q.want) begin
                     s_d.status.fail      = 1'b1;
                     s_d.status.fail_addr = s_q.pins.word_addr;
                     s_d.st               = otp_prog_pkg::ST_DONE;
                  end else if (s_q.pins.word_addr == s_q.last) begin
                     s_d.st = otp_prog_pkg::ST_DONE;
                  end else begin
                     s_d.pins.word_addr = s_q.pins.word_addr + 1'b1;
                     s_d.st             = otp_prog_pkg::ST_FINAL_SETUP;
                  end
               end else begin
                  if (s_q.cmd == otp_prog_pkg::CMD_IDENTIFY && ^s_q.din_s2 == 1'b0) begin
                     s_d.status.fail = 1'b1;
                  end
                  s_d.st = otp_prog_pkg::ST_DONE;
               end
            end
         end
         otp_prog_pkg::ST_DONE: begin
            s_d.pins.id_high_voltage = 1'b0;
            s_d.pins.vpp_raise       = 1'b0;
            s_d.pins.vcc_raise       = 1'b0;
            s_d.pins.data_oe         = 1'b0;
            s_d.status.busy          = 1'b0;
            s_d.status.done          = 1'b1;
            s_d.st                   = otp_prog_pkg::ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q              <= '0;
         s_q.st           <= otp_prog_pkg::ST_IDLE;
         s_q.pins.ce_b    <= 1'b1;
         s_q.pins.oe_b    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign pins   = s_q.pins;
   assign status = s_q.status;

endmodule : otp_programmer

// *** otp_programmer_assertions.sv ***
module otp_programmer_assertions #(
   parameter int ADDR_W     = otp_prog_pkg::ADDR_W,
   parameter int MAX_PULSES = otp_prog_pkg::MAX_PULSES
) (
   // watched ports
   input wire logic                     mclk,
   input wire logic                     rst_b,
   input wire logic                     start,
   input wire otp_prog_pkg::cmd_type    cmd,
   input wire logic [ADDR_W-1:0]        cmd_addr,
   input wire logic [ADDR_W-1:0]        last_addr,
   input wire logic [7:0]               cmd_data,
   input wire logic                     id_byte_select_line,
   input wire otp_prog_pkg::pins_type   pins,
   input wire otp_prog_pkg::status_type status,
   input wire logic [7:0]               image_data,
   input wire logic [7:0]               data_pins_in
);
   // ---------------------------------------------------------------
   // helper counters and properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   int lo_q;
   int tries_q;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lo_q    <= 0;
         tries_q <= 0;
      end else begin
         lo_q <= pins.ce_b ? 0 : lo_q + 1;
         if (!status.busy || $changed(pins.word_addr)) begin
            tries_q <= 0;
         end else if ($fell(pins.ce_b) && pins.vpp_raise) begin
            tries_q <= tries_q + 1;
         end
      end
   end
   a_pulse_mode_ok: assert property (!pins.ce_b && pins.vpp_raise |-> pins.oe_b && pins.data_oe)
      else $error("program pulse outside program mode");
   a_pulse_width: assert property ($rose(pins.ce_b) && pins.vpp_raise
      |-> lo_q == otp_prog_pkg::PULSE_CYCLES) else $error("program pulse length wrong");
   a_setup_stable: assert property (!pins.ce_b && pins.vpp_raise
      |-> $stable(pins.word_addr) && $stable(pins.data_out)) else $error("address or data moved");
   a_pulse_limit: assert property (tries_q <= MAX_PULSES)
      else $error("too many pulses on one address");
   a_verify_mode: assert property (pins.vpp_raise && !pins.oe_b |-> pins.ce_b)
      else $error("verify with chip select low");
   a_identify_lines: assert property (pins.id_high_voltage |-> !pins.vpp_raise
      && pins.word_addr[ADDR_W-1:10] == '0 && pins.word_addr[8:1] == '0) else $error("identify lines");
   a_supply_order: assert property (pins.vpp_raise |-> pins.vcc_raise)
      else $error("vpp raised without vcc");
   a_no_contention: assert property (!pins.oe_b |-> !pins.data_oe)
      else $error("host drives data while gate low");
   a_addr_ascend: assert property (pins.vpp_raise && $past(pins.vpp_raise) && $changed(pins.word_addr)
      |-> pins.word_addr == $past(pins.word_addr) + 1'b1) else $error("address not in sequence");
   a_data_hold: assert property ($rose(pins.ce_b) && pins.vpp_raise |-> pins.data_oe [*8])
      else $error("data released too early");
   cover property ($rose(pins.ce_b) && pins.vpp_raise);
   cover property (pins.id_high_voltage && !pins.oe_b);
   cover property (status.done && status.fail);
endmodule : otp_programmer_assertions
bind otp_programmer otp_programmer_assertions #(.ADDR_W(ADDR_W), .MAX_PULSES(MAX_PULSES)) u_chk (
   .mclk, .rst_b, .start, .cmd, .cmd_addr, .last_addr, .cmd_data, .id_byte_select_line,
   .pins, .status, .image_data, .data_pins_in);

// *** otp_programmer_tb.sv ***
module otp_programmer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // bench
   // ---------------------------------------------------------------
   localparam int NP = 4;  // short retry limit keeps the failing case brief
   localparam logic [7:0] MAKER = 8'h97;  // arbitrary value
   localparam logic [7:0] DEV   = 8'h0E;  // arbitrary value
   typedef struct {otp_prog_pkg::cmd_type c; logic [18:0] a, l; logic s; logic [7:0] rd; logic f;} row_type;
   logic mclk, rst_b, start, sel, stuck;
   otp_prog_pkg::cmd_type cmd;
   logic [18:0] cmd_addr, last_addr;
   logic [7:0] image_data, data_pins_in;
   otp_prog_pkg::pins_type pins;
   otp_prog_pkg::status_type status;
   int mismatches, comparisons, pulses;
   row_type rows [7];
   function automatic logic [7:0] img(input logic [18:0] a);
      return {a[4:0], 3'b101};
   endfunction : img
   assign image_data = img(pins.word_addr);
   otp_programmer #(.MAX_PULSES(NP)) u_otp_programmer (.mclk(mclk), .rst_b(rst_b), .start(start),
      .cmd(cmd), .cmd_addr(cmd_addr), .last_addr(last_addr), .cmd_data(8'h00),
      .id_byte_select_line(sel), .pins(pins), .status(status), .image_data(image_data),
      .data_pins_in(data_pins_in));
   otp_eprom_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEV)) u_otp_eprom_model (.pins(pins),
      .stuck(stuck), .data_pins_in(data_pins_in));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(negedge pins.ce_b) if (pins.vpp_raise) pulses++;
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic run(input otp_prog_pkg::cmd_type c, input logic [18:0] a, l, input logic s);
      int n;
      @(posedge mclk);
      start <= 1'b1; cmd <= c; cmd_addr <= a; last_addr <= l; sel <= s;
      @(posedge mclk);
      start <= 1'b0;
      for (n = 0; n < 40000 && status.done !== 1'b1; n++) @(negedge mclk);
      if (n == 40000) begin
         mismatches++;
         conclude();
      end
   endtask : run
   initial begin
      rst_b = 1'b0; start = 1'b0; sel = 1'b0; stuck = 1'b0;
      cmd = otp_prog_pkg::CMD_READ; cmd_addr = '0; last_addr = '0;
      repeat (4) @(posedge mclk);
      chk("reset pins", {pins.ce_b, pins.oe_b, pins.vpp_raise, status.busy}, 4'hC);
      rst_b <= 1'b1;
      rows = '{'{otp_prog_pkg::CMD_IDENTIFY, 0, 0, 0, MAKER, 0},
               '{otp_prog_pkg::CMD_IDENTIFY, 0, 0, 1, DEV, 0},
               '{otp_prog_pkg::CMD_READ, 19'h7FFFF, 19'h7FFFF, 0, 8'hFF, 0},
               '{otp_prog_pkg::CMD_PROGRAM_ALL, 5, 7, 0, 8'h00, 0},
               '{otp_prog_pkg::CMD_READ, 6, 6, 0, img(6), 0},
               '{otp_prog_pkg::CMD_READ, 7, 7, 0, img(7), 0},
               '{otp_prog_pkg::CMD_VERIFY_ALL, 5, 7, 0, 8'h00, 0}};
      foreach (rows[i]) begin
         run(rows[i].c, rows[i].a, rows[i].l, rows[i].s);
         chk("fail", status.fail, rows[i].f);
         if (rows[i].c inside {otp_prog_pkg::CMD_READ, otp_prog_pkg::CMD_IDENTIFY})
            chk("rdata", status.rdata, rows[i].rd);
      end
      stuck <= 1'b1;
      pulses = 0;
      run(otp_prog_pkg::CMD_PROGRAM_ALL, 9, 9, 0);
      chk("stuck fail", {status.fail, 12'h0, status.fail_addr}, {1'b1, 12'h0, 19'h00009});
      chk("pulse count", pulses, NP);
      stuck <= 1'b0;
      run(otp_prog_pkg::CMD_VERIFY_ALL, 8, 8, 0);
      chk("blank verify", {status.fail, 12'h0, status.fail_addr}, {1'b1, 12'h0, 19'h00008});
      run(otp_prog_pkg::CMD_PROGRAM_ALL, 12, 12, 0);
      chk("job fail", status.fail, 1'b0);
      repeat (200) @(posedge mclk);
      chk("idle after job", {pins.vpp_raise, status.busy}, 2'b00);
      // reset in the middle of a program pulse
      @(posedge mclk);
      start <= 1'b1;
      cmd <= otp_prog_pkg::CMD_PROGRAM_ALL;
      cmd_addr <= 19'h00014;
      last_addr <= 19'h00014;
      @(posedge mclk);
      start <= 1'b0;
      repeat (200) @(negedge mclk);
      chk("mid job", {pins.ce_b, pins.vpp_raise, status.busy}, 3'h3);
      @(posedge mclk);
      rst_b <= 1'b0;
      @(negedge mclk);
      chk("reset mid job", {pins.ce_b, pins.oe_b, pins.vpp_raise, status.busy}, 4'hC);
      @(posedge mclk);
      rst_b <= 1'b1;
      run(otp_prog_pkg::CMD_READ, 19'h0000C, 19'h0000C, 1'b0);
      chk("read after reset", status.rdata, img(19'h0000C));
      conclude();
   end
endmodule : otp_programmer_tb
